// ---- hw/bm_pkg.sv ----
// constants and types shared by the byte mover control block
package bm_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NCH = 7; // number of channels
	localparam int CH_W = 3; // channel selector width
	localparam int BASE_W = 12; // data ram base address width
	localparam int OFS_W = 10; // address offset and size width
	localparam int ADDR_W = 8; // avalon word address width
	localparam logic [CH_W-1:0] SEL_INVALID = 3'h7; // selector code with no channel
	// ----------------------------------------------------------------
	// register indices (word addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] IDX_CONFIG = 8'hC9; // channel_config
	localparam logic [ADDR_W-1:0] IDX_BASE_LO = 8'hCA; // base_address low byte
	localparam logic [ADDR_W-1:0] IDX_BASE_HI = 8'hCB; // base_address high bits
	localparam logic [ADDR_W-1:0] IDX_OFS_LO = 8'hCC; // address_offset low byte
	localparam logic [ADDR_W-1:0] IDX_OFS_HI = 8'hCD; // address_offset high bits
	localparam logic [ADDR_W-1:0] IDX_SIZE_LO = 8'hCE; // transfer_size low byte
	localparam logic [ADDR_W-1:0] IDX_SIZE_HI = 8'hCF; // transfer_size high bits
	localparam logic [ADDR_W-1:0] IDX_SEL = 8'hD1; // channel_selector
	localparam logic [ADDR_W-1:0] IDX_ENABLE = 8'hD2; // channel_enables
	localparam logic [ADDR_W-1:0] IDX_FULL = 8'hD3; // full_flags
	localparam logic [ADDR_W-1:0] IDX_HALF = 8'hD4; // half_flags
	localparam logic [ADDR_W-1:0] IDX_BUSY = 8'hD5; // channel_busy_start
	localparam logic [ADDR_W-1:0] IDX_MODE = 8'hD6; // channel_mode
	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CFG_FULL_EN = 7; // full_irq_enable
	localparam int CFG_HALF_EN = 6; // half_irq_enable
	localparam int CFG_STALL = 5; // stall bit
	localparam int CFG_ENDIAN = 4; // one is big endian
	localparam int MODE_WRAP = 0; // rollover enable
	localparam logic [7:0] RST_REG = 8'h00; // reset value of every register
	localparam logic [1:0] BUS_READY_PHASE = 2'h1; // phase at which the answer is built
	// ----------------------------------------------------------------
	// transfer_function codes
	// ----------------------------------------------------------------
	localparam logic [3:0] FN_RAM_TO_ENC = 4'h0;
	localparam logic [3:0] FN_ENC_TO_RAM = 4'h1;
	localparam logic [3:0] FN_RAM_TO_CRC = 4'h2;
	localparam logic [3:0] FN_RAM_TO_SPI = 4'h3;
	localparam logic [3:0] FN_SPI_TO_RAM = 4'h4;
	localparam logic [3:0] FN_RAM_TO_KEY = 4'h5;
	localparam logic [3:0] FN_RAM_TO_BLK = 4'h6;
	localparam logic [3:0] FN_RAM_TO_XOR = 4'h7;
	localparam logic [3:0] FN_OUT_TO_RAM = 4'h8;
	// engine states
	typedef enum {ST_IDLE, ST_LOAD, ST_ISSUE} bm_state_t;
endpackage : bm_pkg

// ---- hw/bm_chan_bank.sv ----
// per-channel storage with one masked write port and two registered read ports
module bm_chan_bank #(
	parameter int W = 22,
	parameter int N = 7,
	parameter int IW = 3
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [IW-1:0] wr_idx,
	input wire logic [W-1:0] wr_data,
	input wire logic [W-1:0] wr_mask,
	input wire logic [IW-1:0] rd_a_idx,
	output logic [W-1:0] rd_a_data,
	input wire logic [IW-1:0] rd_b_idx,
	output logic [W-1:0] rd_b_data
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [N-1:0][W-1:0] mem; // one word per channel
	for (genvar i = 0; i < N; i++)
	begin : g_word
		// masked write keeps the bits outside the mask
		always_ff @(posedge clk or negedge reset_n)
		begin
			if (!reset_n)
				mem[i] <= '0;
			else if (wr_en && wr_idx == IW'(i))
				mem[i] <= (mem[i] & ~wr_mask) | (wr_data & wr_mask);
		end
	end
	// ----------------------------------------------------------------
	// registered reads, out of range reads give zero
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_a_data <= '0;
			rd_b_data <= '0;
		end
		else
		begin
			rd_a_data <= (int'(rd_a_idx) < N) ? mem[rd_a_idx] : '0;
			rd_b_data <= (int'(rd_b_idx) < N) ? mem[rd_b_idx] : '0;
		end
	end
endmodule : bm_chan_bank

// ---- hw/bm_channel_ctrl.sv ----
// byte mover channel control: registers, channel engine and interrupt
// Functional notes
// - writing one to busy bit forces start
// - busy bit reads one while transferring
// - three-bit selector, code seven is invalid
// - mode and config reach selected channel
// - selector bits seven to three read zero
// - offset runs to size minus one, completes
// - rollover returns offset to zero at completion
// - config bit seven enables full interrupt
// - config bit six enables half interrupt
// - stall bit holds the channel still
// - config bit four picks byte order for the two encoder functions only
// - four-bit function picks one of nine
// - offset steps per byte; address base plus offset
// - full flag at size minus one, sticky
// - half flag at half size, odd rounded up
module bm_channel_ctrl
	import bm_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [bm_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [bm_pkg::NCH-1:0] transfer_function_request,
	output logic xfer_valid,
	output logic [bm_pkg::CH_W-1:0] xfer_channel,
	output logic [bm_pkg::BASE_W-1:0] xfer_address,
	output logic [3:0] xfer_function,
	output logic xfer_big_endian,
	input wire logic xfer_done,
	output logic irq
);
	import bm_pkg::*;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// lowest eligible channel
	function automatic logic [CH_W-1:0] first_set(input logic [NCH-1:0] v);
		logic [CH_W-1:0] r;
		r = '0;
		for (int i = NCH - 1; i >= 0; i--)
			if (v[i])
				r = CH_W'(i);
		return r;
	endfunction : first_set
	// only encoder transfers take the byte order bit
	function automatic logic is_multi(input logic [3:0] f);
		return (f == FN_RAM_TO_ENC) || (f == FN_ENC_TO_RAM);
	endfunction : is_multi
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [CH_W-1:0] sel; // channel_selector
	logic [NCH-1:0] enables; // channel_enables
	logic [NCH-1:0] busy; // live busy bits
	logic [NCH-1:0] full_flags; // sticky full-length flags
	logic [NCH-1:0] half_flags; // sticky mid-point flags
	logic [NCH-1:0][7:0] cfg; // channel_config copies
	logic [NCH-1:0] wrap; // channel_mode rollover bits
	logic [NCH-1:0][OFS_W-1:0] ofs; // address_offset counters
	logic [1:0] bus_phase; // cycles spent on the current request
	bm_state_t state; // engine state
	logic [CH_W-1:0] act_ch; // channel owned by the engine
	logic [CH_W-1:0] bank_b_idx; // bank row read for the engine, one cycle ahead of load
	logic [BASE_W+OFS_W-1:0] bank_a; // base and size of selected channel
	logic [BASE_W+OFS_W-1:0] bank_b; // base and size of active channel
	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire wr_acc = avs_write && !avs_waitrequest; // write takes effect
	wire [7:0] wd = avs_writedata[7:0]; // registers are one byte wide
	wire sel_ok = sel != SEL_INVALID;
	wire ind_wr = wr_acc && sel_ok;
	wire wr_cfg = ind_wr && avs_address == IDX_CONFIG;
	wire wr_mode = ind_wr && avs_address == IDX_MODE;
	wire wr_ol = ind_wr && avs_address == IDX_OFS_LO;
	wire wr_oh = ind_wr && avs_address == IDX_OFS_HI;
	wire wr_bl = avs_address == IDX_BASE_LO;
	wire wr_bh = avs_address == IDX_BASE_HI;
	wire wr_sl = avs_address == IDX_SIZE_LO;
	wire wr_sh = avs_address == IDX_SIZE_HI;
	wire bank_we = ind_wr && (wr_bl || wr_bh || wr_sl || wr_sh);
	// bank word: size above base
	wire [BASE_W+OFS_W-1:0] bank_wd = {wd[1:0], wd, wd[3:0], wd};
	wire [BASE_W+OFS_W-1:0] bank_wm = {{2{wr_sh}}, {8{wr_sl}}, {4{wr_bh}}, {8{wr_bl}}};
	wire [OFS_W-1:0] sel_ofs = ofs[sel];
	wire [7:0] sel_cfg = cfg[sel];
	// ----------------------------------------------------------------
	// read multiplexer, indirect registers read zero on the invalid code
	// ----------------------------------------------------------------
	wire [7:0] rd_ind =
		!sel_ok ? RST_REG :
		avs_address == IDX_CONFIG ? sel_cfg :
		avs_address == IDX_MODE ? {7'h00, wrap[sel]} :
		avs_address == IDX_BASE_LO ? bank_a[7:0] :
		avs_address == IDX_BASE_HI ? {4'h0, bank_a[11:8]} :
		avs_address == IDX_OFS_LO ? sel_ofs[7:0] :
		avs_address == IDX_OFS_HI ? {6'h00, sel_ofs[9:8]} :
		avs_address == IDX_SIZE_LO ? bank_a[19:12] :
		avs_address == IDX_SIZE_HI ? {6'h00, bank_a[21:20]} : 8'h00;
	wire [7:0] rd_mux =
		avs_address == IDX_SEL ? {5'h00, sel} :
		avs_address == IDX_ENABLE ? {1'b0, enables} :
		avs_address == IDX_FULL ? {1'b0, full_flags} :
		avs_address == IDX_HALF ? {1'b0, half_flags} :
		avs_address == IDX_BUSY ? {1'b0, busy} : rd_ind;
	// ----------------------------------------------------------------
	// bus handshake: answer two cycles after the request appears
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bus_phase <= 2'h0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end
		else if (!avs_waitrequest)
		begin
			// request taken this edge, back to waiting
			bus_phase <= 2'h0;
			avs_waitrequest <= 1'b1;
		end
		else if (avs_read || avs_write)
		begin
			// bank read data are valid in phase one
			bus_phase <= bus_phase + 2'h1;
			if (bus_phase == BUS_READY_PHASE)
			begin
				avs_waitrequest <= 1'b0;
				avs_readdata <= {24'h000000, rd_mux};
			end
		end
	end
	// ----------------------------------------------------------------
	// base and size storage
	// ----------------------------------------------------------------
	bm_chan_bank #(
		.W(BASE_W + OFS_W),
		.N(NCH),
		.IW(CH_W)
	) u_bank (
		.clk(clk),
		.reset_n(reset_n),
		.wr_en(bank_we),
		.wr_idx(sel),
		.wr_data(bank_wd),
		.wr_mask(bank_wm),
		.rd_a_idx(sel),
		.rd_a_data(bank_a),
		.rd_b_idx(bank_b_idx),
		.rd_b_data(bank_b)
	);
	// ----------------------------------------------------------------
	// engine decode
	// ----------------------------------------------------------------
	wire [BASE_W-1:0] act_base = bank_b[BASE_W-1:0];
	wire [OFS_W-1:0] act_size = bank_b[BASE_W+OFS_W-1:BASE_W];
	wire [OFS_W-1:0] act_ofs = ofs[act_ch];
	wire [7:0] act_cfg = cfg[act_ch];
	wire [NCH-1:0] stall_vec; // stall bits of all channels
	wire [NCH-1:0] full_en_vec; // full interrupt enables
	wire [NCH-1:0] half_en_vec; // half interrupt enables
	wire [NCH-1:0] ready = busy & ~stall_vec;
	wire hw_step = state == ST_ISSUE && xfer_done; // one byte moved
	wire [CH_W-1:0] pick_ch = first_set(ready);
	// read the picked row while idle so base and size stand when load uses them
	assign bank_b_idx = (state == ST_IDLE) ? pick_ch : act_ch;
	wire last = act_ofs == act_size - 10'h001;
	wire [OFS_W-1:0] half_pt = {1'b0, act_size[9:1]} + {9'h000, act_size[0]};
	wire [NCH-1:0] ch_hot = NCH'(1) << act_ch; // active channel one-hot
	wire [NCH-1:0] done_vec = (hw_step && last) ? ch_hot : '0; // completion
	wire [NCH-1:0] half_vec = (hw_step && act_ofs == half_pt) ? ch_hot : '0;
	wire [NCH-1:0] start_vec = (wr_acc && avs_address == IDX_BUSY) ? wd[NCH-1:0] : '0;
	wire [NCH-1:0] full_clr = (wr_acc && avs_address == IDX_FULL) ? wd[NCH-1:0] : '0;
	wire [NCH-1:0] half_clr = (wr_acc && avs_address == IDX_HALF) ? wd[NCH-1:0] : '0;
	wire [NCH-1:0] next_busy = (busy & ~done_vec) | start_vec | (enables & transfer_function_request);
	wire [OFS_W-1:0] next_ofs = last ? (wrap[act_ch] ? '0 : act_ofs) : act_ofs + 10'h001;
	// ----------------------------------------------------------------
	// per-channel settings and offset counters
	// ----------------------------------------------------------------
	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		assign stall_vec[c] = cfg[c][CFG_STALL];
		assign full_en_vec[c] = cfg[c][CFG_FULL_EN];
		assign half_en_vec[c] = cfg[c][CFG_HALF_EN];
		// config and mode of the selected channel
		always_ff @(posedge clk or negedge reset_n)
		begin
			if (!reset_n)
			begin
				cfg[c] <= RST_REG;
				wrap[c] <= 1'b0;
			end
			else
			begin
				if (wr_cfg && sel == CH_W'(c))
					cfg[c] <= wd;
				if (wr_mode && sel == CH_W'(c))
					wrap[c] <= wd[MODE_WRAP];
			end
		end
		// engine step wins over a software write in the same cycle
		always_ff @(posedge clk or negedge reset_n)
		begin
			if (!reset_n)
				ofs[c] <= '0;
			else if (hw_step && act_ch == CH_W'(c))
				ofs[c] <= next_ofs;
			else if (wr_ol && sel == CH_W'(c))
				ofs[c][7:0] <= wd;
			else if (wr_oh && sel == CH_W'(c))
				ofs[c][9:8] <= wd[1:0];
		end
	end
	// ----------------------------------------------------------------
	// direct registers and sticky flags, a set beats a clear
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sel <= '0;
			enables <= '0;
			busy <= '0;
			full_flags <= '0;
			half_flags <= '0;
			irq <= 1'b0;
		end
		else
		begin
			if (wr_acc && avs_address == IDX_SEL)
				sel <= wd[CH_W-1:0];
			if (wr_acc && avs_address == IDX_ENABLE)
				enables <= wd[NCH-1:0];
			busy <= next_busy;
			full_flags <= (full_flags & ~full_clr) | done_vec;
			half_flags <= (half_flags & ~half_clr) | half_vec;
			irq <= |((full_flags & full_en_vec) | (half_flags & half_en_vec));
		end
	end
	// ----------------------------------------------------------------
	// engine: pick, load base and size, issue one byte, wait
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= ST_IDLE;
			act_ch <= '0;
			xfer_valid <= 1'b0;
			xfer_channel <= '0;
			xfer_address <= '0;
			xfer_function <= FN_RAM_TO_ENC;
			xfer_big_endian <= 1'b0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					// stalled channels are never picked
					if (|ready)
					begin
						act_ch <= pick_ch;
						state <= ST_LOAD;
					end
				end
				ST_LOAD:
				begin
					// stall may arrive while loading
					if (ready[act_ch])
					begin
						xfer_valid <= 1'b1;
						xfer_channel <= act_ch;
						xfer_address <= act_base + BASE_W'(act_ofs);
						xfer_function <= act_cfg[3:0];
						xfer_big_endian <= act_cfg[CFG_ENDIAN] && is_multi(act_cfg[3:0]);
						state <= ST_ISSUE;
					end
					else
						state <= ST_IDLE;
				end
				ST_ISSUE:
				begin
					if (xfer_done)
					begin
						xfer_valid <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_req_start;
		(avs_read || avs_write) && avs_waitrequest && bus_phase == 2'h0;
	endsequence
	sequence s_answer;
		avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	property p_bus_answer;
		@(posedge clk) disable iff (!reset_n) s_req_start |-> s_answer;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer not after two cycles");
	property p_busy_top;
		@(posedge clk) disable iff (!reset_n)
			avs_read && !avs_waitrequest && avs_address == IDX_BUSY |-> avs_readdata[7] == 1'b0;
	endproperty
	a_busy_top: assert property (p_busy_top) else $error("busy bit seven read nonzero");
	property p_sel_upper;
		@(posedge clk) disable iff (!reset_n)
			avs_read && !avs_waitrequest && avs_address == IDX_SEL |-> avs_readdata[7:3] == 5'h00;
	endproperty
	a_sel_upper: assert property (p_sel_upper) else $error("selector upper bits nonzero");
	property p_invalid_read;
		@(posedge clk) disable iff (!reset_n)
			avs_read && !avs_waitrequest && avs_address == IDX_CONFIG && $past(sel) == SEL_INVALID
			&& sel == SEL_INVALID |-> avs_readdata == 32'h0000_0000;
	endproperty
	a_invalid_read: assert property (p_invalid_read) else $error("invalid selector read nonzero");
	property p_start;
		@(posedge clk) disable iff (!reset_n) start_vec[0] |=> busy[0];
	endproperty
	a_start: assert property (p_start) else $error("force start did not set busy");
	property p_no_start;
		@(posedge clk) disable iff (!reset_n)
			wr_acc && avs_address == IDX_BUSY && !wd[0] && !busy[0] && !(enables[0] && transfer_function_request[0])
			|=> !busy[0];
	endproperty
	a_no_start: assert property (p_no_start) else $error("writing zero started a channel");
	property p_stall;
		@(posedge clk) disable iff (!reset_n) $rose(xfer_valid) |-> !$past(stall_vec[act_ch]);
	endproperty
	a_stall: assert property (p_stall) else $error("stalled channel issued a byte");
	property p_full;
		@(posedge clk) disable iff (!reset_n) hw_step && last |=> full_flags[$past(act_ch)] && !busy[$past(act_ch)]
			|| start_vec != '0 || transfer_function_request != '0;
	endproperty
	a_full: assert property (p_full) else $error("completion did not flag and idle");
	property p_wrap;
		@(posedge clk) disable iff (!reset_n) hw_step && last && wrap[act_ch] |=> ofs[$past(act_ch)] == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("rollover did not clear offset");
	property p_step;
		@(posedge clk) disable iff (!reset_n) hw_step && !last |=> ofs[$past(act_ch)] == $past(act_ofs) + 10'h001;
	endproperty
	a_step: assert property (p_step) else $error("offset did not step by one");
	property p_half;
		@(posedge clk) disable iff (!reset_n) hw_step && act_ofs == half_pt |=> half_flags[$past(act_ch)];
	endproperty
	a_half: assert property (p_half) else $error("mid-point flag not set");
endmodule : bm_channel_ctrl

// ---- test/bm_transfer_function_model.sv ----
// peripheral side model: finishes each offered byte after a set lag
module bm_transfer_function_model
	import bm_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] lag,
	input wire logic xfer_valid,
	output logic xfer_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_cnt; // cycles spent on the offered byte
	// ----------------------------------------------------------------
	// done pulse
	// ----------------------------------------------------------------
	// one pulse per byte, never while nothing is offered
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			xfer_done <= 1'b0;
			wait_cnt <= 4'h0;
		end
		else if (xfer_valid && !xfer_done)
		begin
			// slow answer when lag is above zero
			if (wait_cnt == lag)
			begin
				xfer_done <= 1'b1;
				wait_cnt <= 4'h0;
			end
			else
				wait_cnt <= wait_cnt + 4'h1;
		end
		else
			xfer_done <= 1'b0;
	end
endmodule : bm_transfer_function_model

// ---- test/tb_top.sv ----
// self-checking bench for the byte mover channel control
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bm_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [ADDR_W-1:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_val;
	logic avs_waitrequest, xfer_valid, xfer_big_endian, xfer_done, irq;
	logic [NCH-1:0] transfer_function_request = 7'h00; // only software starts here
	logic [CH_W-1:0] xfer_channel;
	logic [BASE_W-1:0] xfer_address;
	logic [3:0] xfer_function, lag = 4'h0;
	logic [BASE_W-1:0] addrs[$]; // addresses of finished bytes
	logic ends[$]; // byte order flag of finished bytes
	logic [7:0] tags[$]; // channel and function of finished bytes
	int errors = 0, n_checks = 0, n_done = 0, irq_at = 0, cycles = 0;
	always #4 clk = ~clk;
	bm_channel_ctrl u_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .transfer_function_request(transfer_function_request), .xfer_valid(xfer_valid),
		.xfer_channel(xfer_channel), .xfer_address(xfer_address), .xfer_function(xfer_function),
		.xfer_big_endian(xfer_big_endian), .xfer_done(xfer_done), .irq(irq));
	bm_transfer_function_model u_peer (.clk(clk), .reset_n(reset_n), .lag(lag), .xfer_valid(xfer_valid), .xfer_done(xfer_done));
	// ----------------------------------------------------------------
	// monitor and timeout
	// ----------------------------------------------------------------
	// log each finished byte and how many were done when irq rose
	always @(posedge clk)
	begin
		cycles++;
		if (xfer_valid === 1'b1 && xfer_done === 1'b1)
		begin
			addrs.push_back(xfer_address);
			ends.push_back(xfer_big_endian);
			tags.push_back({1'b0, xfer_channel, xfer_function});
			n_done++;
		end
		if (irq === 1'b1 && irq_at == 0)
			irq_at = n_done;
		if (cycles == 30000)
		begin
			errors++;
			results();
		end
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic results();
		if (errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			errors++;
		end
	endtask : chk
	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !wr;
		avs_write <= wr;
		// wait for the answer; only the bench timeout ends a hang
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		rd_val = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk(what, {24'h0, exp}, rd_val);
	endtask : rd_chk
	// select first, then program the channel's settings
	task automatic setup(input int ch, input logic [11:0] base, input logic [9:0] size, input logic [7:0] cfg,
		input logic [7:0] mode);
		bus(1'b1, IDX_SEL, 8'(ch));
		bus(1'b1, IDX_CONFIG, cfg);
		bus(1'b1, IDX_MODE, mode);
		bus(1'b1, IDX_BASE_LO, base[7:0]);
		bus(1'b1, IDX_BASE_HI, {4'h0, base[11:8]});
		bus(1'b1, IDX_SIZE_LO, size[7:0]);
		bus(1'b1, IDX_SIZE_HI, {6'h0, size[9:8]});
		bus(1'b1, IDX_OFS_LO, 8'h00);
		bus(1'b1, IDX_OFS_HI, 8'h00);
		addrs.delete();
		ends.delete();
		tags.delete();
		n_done = 0;
		irq_at = 0;
	endtask : setup
	// poll the busy register until the channel goes idle
	task automatic wait_idle(input int ch);
		repeat (100)
		begin
			bus(1'b0, IDX_BUSY, 8'h00);
			if (rd_val[ch] === 1'b0)
				break;
		end
		chk("busy after run", 32'h0, rd_val);
	endtask : wait_idle
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] regs[5] = '{IDX_CONFIG, IDX_SEL, IDX_BUSY, IDX_MODE, 8'h00};
		foreach (regs[i])
			rd_chk("reset value", regs[i], RST_REG);
	endtask : t_reset
	task automatic t_select();
		bus(1'b1, IDX_SEL, 8'hFF);
		rd_chk("selector", IDX_SEL, 8'h07);
		bus(1'b1, IDX_CONFIG, 8'h15);
		rd_chk("config invalid sel", IDX_CONFIG, 8'h00);
		bus(1'b1, IDX_SEL, 8'h06);
		rd_chk("config dropped", IDX_CONFIG, 8'h00);
		bus(1'b1, IDX_CONFIG, 8'h13);
		bus(1'b1, IDX_SEL, 8'h05);
		bus(1'b1, IDX_CONFIG, 8'h02);
		bus(1'b1, IDX_MODE, 8'hFF);
		rd_chk("mode", IDX_MODE, 8'h01);
		bus(1'b1, IDX_SEL, 8'h06);
		rd_chk("config ch6", IDX_CONFIG, 8'h13);
		rd_chk("mode ch6", IDX_MODE, 8'h00);
	endtask : t_select
	task automatic t_functions();
		bus(1'b1, IDX_SEL, 8'h04);
		for (int f = 0; f <= 8; f++)
		begin
			bus(1'b1, IDX_CONFIG, 8'(f));
			rd_chk("function", IDX_CONFIG, 8'(f));
		end
	endtask : t_functions
	task automatic t_half();
		lag <= 4'h2;
		setup(0, 12'h120, 10'd5, 8'h51, 8'h00);
		bus(1'b1, IDX_BUSY, 8'h01);
		wait_idle(0);
		chk("dones at irq", 32'd4, irq_at);
		chk("bytes", 32'd5, n_done);
		foreach (addrs[i])
		begin
			chk("address", 32'h120 + i, {20'h0, addrs[i]});
			chk("big endian", 32'h1, {31'h0, ends[i]});
			chk("channel function", 32'h01, {24'h0, tags[i]});
		end
		rd_chk("offset", IDX_OFS_LO, 8'h04);
		rd_chk("full flags", IDX_FULL, 8'h01);
		rd_chk("half flags", IDX_HALF, 8'h01);
		chk("irq half", 32'h1, {31'h0, irq});
		bus(1'b1, IDX_HALF, 8'h01);
		bus(1'b1, IDX_FULL, 8'h01);
		rd_chk("half cleared", IDX_HALF, 8'h00);
		chk("irq off", 32'h0, {31'h0, irq});
	endtask : t_half
	task automatic t_wrap();
		lag <= 4'h0;
		setup(2, 12'h3F0, 10'd4, 8'h93, 8'h01);
		bus(1'b1, IDX_BUSY, 8'h04);
		wait_idle(2);
		chk("dones at irq", 32'd4, irq_at);
		chk("endian ignored", 32'h0, {31'h0, ends[0]});
		chk("bytes", 32'd4, n_done);
		foreach (addrs[i])
		begin
			chk("address", 32'h3F0 + i, {20'h0, addrs[i]});
			chk("channel function", 32'h23, {24'h0, tags[i]});
		end
		rd_chk("offset wrapped", IDX_OFS_LO, 8'h00);
		bus(1'b1, IDX_FULL, 8'h04);
		bus(1'b1, IDX_HALF, 8'h04);
	endtask : t_wrap
	task automatic t_stall();
		lag <= 4'h1;
		setup(1, 12'h200, 10'd2, 8'h22, 8'h00);
		bus(1'b1, IDX_BUSY, 8'h82);
		bus(1'b1, IDX_BUSY, 8'h00);
		repeat (20) @(posedge clk);
		rd_chk("busy stalled", IDX_BUSY, 8'h02);
		chk("stalled bytes", 32'd0, n_done);
		bus(1'b1, IDX_CONFIG, 8'h02);
		wait_idle(1);
		chk("resumed bytes", 32'd2, n_done);
		foreach (addrs[i])
		begin
			chk("address", 32'h200 + i, {20'h0, addrs[i]});
			chk("channel function", 32'h12, {24'h0, tags[i]});
		end
		bus(1'b1, IDX_FULL, 8'h02);
		bus(1'b1, IDX_HALF, 8'h02);
	endtask : t_stall
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_select();
		t_functions();
		t_half();
		t_wrap();
		t_stall();
		results();
	end
endmodule : tb_top
